// *** rtl/zone_pkg.sv ***
// Shared constants and types for the zone overrun and debounce block
package zone_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ      = 50_000_000;
    localparam int unsigned TICK_TIME_US     = 10_000;
    localparam int unsigned TICK_CYCLES      =
        CLK_FREQ_HZ / 1_000_000 * TICK_TIME_US;
    localparam int unsigned OVERRUN_MAX_S    = 65;
    localparam int unsigned DEBOUNCE_RST_MS  = 100;
    localparam int unsigned DEBOUNCE_MAX_MS  = 2_000;

    // ------------------------------------------------------------
    // Settings, in ticks or millimetres
    // ------------------------------------------------------------
    localparam logic [15:0] OVERRUN_RESET    = 16'h0000;
    localparam logic [15:0] OVERRUN_TIME_MAX =
        16'(OVERRUN_MAX_S * 1_000_000 / TICK_TIME_US);
    localparam logic [15:0] OVERRUN_DIST_MAX = 16'hFFFF;
    localparam logic [7:0]  DEBOUNCE_RESET   =
        8'(DEBOUNCE_RST_MS * 1_000 / TICK_TIME_US);
    localparam logic [7:0]  DEBOUNCE_MAX     =
        8'(DEBOUNCE_MAX_MS * 1_000 / TICK_TIME_US);
    localparam logic [1:0]  CTRL_RESET       = 2'h0;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFFSET      = 8'h00;
    localparam logic [7:0]  OVR_UP_OFFSET    = 8'h04;
    localparam logic [7:0]  OVR_DN_OFFSET    = 8'h08;
    localparam logic [7:0]  DEBOUNCE_OFFSET  = 8'h0C;
    localparam logic [7:0]  STATUS_OFFSET    = 8'h10;
    localparam logic [7:0]  CHATTER_L_OFFSET = 8'h14;
    localparam logic [7:0]  CHATTER_R_OFFSET = 8'h18;
    localparam int unsigned CTRL_UP_DIST_BIT = 0;
    localparam int unsigned CTRL_DN_DIST_BIT = 1;

    typedef struct packed {
        logic        distance_mode;
        logic [15:0] overrun;
    } zone_cfg_type;

    // Range limit depends on the unit in force
    function automatic logic [15:0] clamp_overrun(
        input logic [15:0] value,
        input logic        distance_mode
    );
        logic [15:0] limit;
        limit = distance_mode ? OVERRUN_DIST_MAX : OVERRUN_TIME_MAX;
        clamp_overrun = (value > limit) ? limit : value;
    endfunction

endpackage

// *** rtl/sensor_debounce.sv ***
// Hold-type debounce filter for one photo-sensor input
`timescale 1ns/1ns
module sensor_debounce #(
    parameter int unsigned HOLD_WIDTH = 8
) (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic                  tick,
    input  wire logic                  raw,
    input  wire logic [HOLD_WIDTH-1:0] period,
    output logic                       filtered,
    output logic                       holding,
    output logic                       chatter
);
    logic [HOLD_WIDTH-1:0] hold_cnt;
    logic [HOLD_WIDTH-1:0] next_hold_cnt;
    logic                  next_filtered;
    logic                  raw_prev;

    assign holding = (hold_cnt != {HOLD_WIDTH{1'b0}});
    assign chatter = holding && (raw != raw_prev);

    // No leading delay: edges pass at once, then the hold begins
    always_comb begin
        next_hold_cnt = hold_cnt;
        next_filtered = filtered;
        if (!holding) begin
            if (raw != filtered) begin
                next_filtered = raw;
                next_hold_cnt = period;
            end
        end else if (tick) begin
            next_hold_cnt = hold_cnt - {{(HOLD_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_cnt <= {HOLD_WIDTH{1'b0}};
            filtered <= 1'b0;
            raw_prev <= 1'b0;
        end else begin
            hold_cnt <= next_hold_cnt;
            filtered <= next_filtered;
            raw_prev <= raw;
        end
    end
endmodule

// *** rtl/overrun_timer.sv ***
// Arrival overrun counter for one zone, in ticks or travel pulses
`timescale 1ns/1ns
module overrun_timer (
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic                   start,
    input  wire logic                   tick,
    input  wire logic                   travel,
    input  zone_pkg::zone_cfg_type      cfg,
    output logic                        busy
);
    logic [15:0] remain;
    logic [15:0] next_remain;
    logic        step;

    assign busy = (remain != 16'h0000);
    // Unit follows the zone's mode
    assign step = cfg.distance_mode ? travel : tick;

    always_comb begin
        next_remain = remain;
        if (start) begin
            next_remain = cfg.overrun;
        end else if (busy && step) begin
            next_remain = remain - 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            remain <= 16'h0000;
        end else begin
            remain <= next_remain;
        end
    end
endmodule

// *** rtl/zone_induct_debounce.sv ***
// Two-zone arrival overrun and shared photo-sensor debounce
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ns

// Function
// - Blocking during arrival keeps the roller motor on for the overrun.
// - Time overrun resets to zero, limited to sixty-five seconds.
// - Upstream and downstream zones hold separate overrun settings.
// - Distance mode counts millimetres, resets to zero, limit 65535.
// - After a filtered change, further input changes are ignored for the hold.
// - A blocking edge reaches the filtered output at once.
// - A clearing edge reaches the filtered output at once, then holds.
// - Changes ignored during a hold bump a readable chatter counter.
// - Debounce resets to 0.1 seconds, limited to two seconds.
// - One debounce setting serves both left and right sensors.
module zone_induct_debounce #(
    parameter int unsigned TICK_CYCLES = zone_pkg::TICK_CYCLES
) (
    input  wire logic        REF_CLK,
    input  wire logic        RST_B,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WSTRB,
    input  wire logic        RSTRB,
    output logic      [31:0] RDATA,
    input  wire logic        SENSOR_L,
    input  wire logic        SENSOR_R,
    input  wire logic        TRAVEL_PULSE_UP,
    input  wire logic        TRAVEL_PULSE_DN,
    input  wire logic        ARRIVING_UP,
    input  wire logic        ARRIVING_DN,
    output logic             ROLLER_MOTOR_UP,
    output logic             ROLLER_MOTOR_DN,
    output logic             SENSOR_L_FILTERED,
    output logic             SENSOR_R_FILTERED
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [3:0]             pin_raw;
    logic [3:0]             sync_a;
    logic [3:0]             sync_b;
    logic [1:0]             travel_prev;
    logic [1:0]             travel_edge;
    logic [31:0]            tick_cnt;
    logic [31:0]            next_tick_cnt;
    logic                   tick;
    zone_pkg::zone_cfg_type cfg_up;
    zone_pkg::zone_cfg_type cfg_dn;
    zone_pkg::zone_cfg_type next_cfg_up;
    zone_pkg::zone_cfg_type next_cfg_dn;
    logic [7:0]             debounce;
    logic [7:0]             next_debounce;
    logic                   filt_l;
    logic                   filt_r;
    logic                   hold_l;
    logic                   hold_r;
    logic                   chat_l;
    logic                   chat_r;
    logic                   filt_l_prev;
    logic                   filt_r_prev;
    logic [15:0]            chatter_l;
    logic [15:0]            chatter_r;
    logic [15:0]            next_chatter_l;
    logic [15:0]            next_chatter_r;
    logic                   start_up;
    logic                   start_dn;
    logic                   busy_up;
    logic                   busy_dn;
    logic [31:0]            next_rdata;
    logic                   wr_ctrl;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    assign pin_raw = {TRAVEL_PULSE_DN, TRAVEL_PULSE_UP,
                      SENSOR_R, SENSOR_L};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge REF_CLK or negedge RST_B) begin
                if (!RST_B) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= pin_raw[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    // Travel pulse edges, one per millimetre
    assign travel_edge = sync_b[3:2] & ~travel_prev;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            travel_prev <= 2'h0;
        end else begin
            travel_prev <= sync_b[3:2];
        end
    end

    // ------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------
    // One-cycle enable every 10 ms; keeps a single clock domain
    assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

    always_comb begin
        next_tick_cnt = tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            tick_cnt <= 32'h0000_0000;
        end else begin
            tick_cnt <= next_tick_cnt;
        end
    end

    // ------------------------------------------------------------
    // Settings registers
    // ------------------------------------------------------------
    assign wr_ctrl = WSTRB && (ADDR == zone_pkg::CTRL_OFFSET);

    // Values are clamped on entry; a mode change clamps again
    always_comb begin
        next_cfg_up   = cfg_up;
        next_cfg_dn   = cfg_dn;
        next_debounce = debounce;
        if (wr_ctrl) begin
            next_cfg_up.distance_mode =
                WDATA[zone_pkg::CTRL_UP_DIST_BIT];
            next_cfg_dn.distance_mode =
                WDATA[zone_pkg::CTRL_DN_DIST_BIT];
            next_cfg_up.overrun = zone_pkg::clamp_overrun(
                cfg_up.overrun, next_cfg_up.distance_mode);
            next_cfg_dn.overrun = zone_pkg::clamp_overrun(
                cfg_dn.overrun, next_cfg_dn.distance_mode);
        end
        if (WSTRB && (ADDR == zone_pkg::OVR_UP_OFFSET)) begin
            next_cfg_up.overrun = zone_pkg::clamp_overrun(
                WDATA[15:0], cfg_up.distance_mode);
        end
        if (WSTRB && (ADDR == zone_pkg::OVR_DN_OFFSET)) begin
            next_cfg_dn.overrun = zone_pkg::clamp_overrun(
                WDATA[15:0], cfg_dn.distance_mode);
        end
        if (WSTRB && (ADDR == zone_pkg::DEBOUNCE_OFFSET)) begin
            next_debounce = (WDATA[7:0] > zone_pkg::DEBOUNCE_MAX) ?
                zone_pkg::DEBOUNCE_MAX : WDATA[7:0];
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cfg_up.distance_mode <= zone_pkg::CTRL_RESET[0];
            cfg_dn.distance_mode <= zone_pkg::CTRL_RESET[1];
            cfg_up.overrun       <= zone_pkg::OVERRUN_RESET;
            cfg_dn.overrun       <= zone_pkg::OVERRUN_RESET;
            debounce             <= zone_pkg::DEBOUNCE_RESET;
        end else begin
            cfg_up   <= next_cfg_up;
            cfg_dn   <= next_cfg_dn;
            debounce <= next_debounce;
        end
    end

    // ------------------------------------------------------------
    // Sensor filters
    // ------------------------------------------------------------
    // Both filters share one period setting
    sensor_debounce #(
        .HOLD_WIDTH (8)
    ) u_deb_l (
        .clk      (REF_CLK),
        .rst_b    (RST_B),
        .tick     (tick),
        .raw      (sync_b[0]),
        .period   (debounce),
        .filtered (filt_l),
        .holding  (hold_l),
        .chatter  (chat_l)
    );

    sensor_debounce #(
        .HOLD_WIDTH (8)
    ) u_deb_r (
        .clk      (REF_CLK),
        .rst_b    (RST_B),
        .tick     (tick),
        .raw      (sync_b[1]),
        .period   (debounce),
        .filtered (filt_r),
        .holding  (hold_r),
        .chatter  (chat_r)
    );

    // Chatter counters wrap; software takes differences
    always_comb begin
        next_chatter_l = chatter_l;
        next_chatter_r = chatter_r;
        if (chat_l) begin
            next_chatter_l = chatter_l + 16'h0001;
        end
        if (chat_r) begin
            next_chatter_r = chatter_r + 16'h0001;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            chatter_l   <= 16'h0000;
            chatter_r   <= 16'h0000;
            filt_l_prev <= 1'b0;
            filt_r_prev <= 1'b0;
        end else begin
            chatter_l   <= next_chatter_l;
            chatter_r   <= next_chatter_r;
            filt_l_prev <= filt_l;
            filt_r_prev <= filt_r;
        end
    end

    // ------------------------------------------------------------
    // Arrival overrun
    // ------------------------------------------------------------
    // Filtered edge, so chatter cannot restart the overrun
    assign start_up = filt_l && !filt_l_prev && ARRIVING_UP;
    assign start_dn = filt_r && !filt_r_prev && ARRIVING_DN;

    overrun_timer u_ovr_up (
        .clk    (REF_CLK),
        .rst_b  (RST_B),
        .start  (start_up),
        .tick   (tick),
        .travel (travel_edge[0]),
        .cfg    (cfg_up),
        .busy   (busy_up)
    );

    overrun_timer u_ovr_dn (
        .clk    (REF_CLK),
        .rst_b  (RST_B),
        .start  (start_dn),
        .tick   (tick),
        .travel (travel_edge[1]),
        .cfg    (cfg_dn),
        .busy   (busy_dn)
    );

    // ------------------------------------------------------------
    // Outputs and read port
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (RSTRB) begin
            case (ADDR)
                zone_pkg::CTRL_OFFSET:
                    next_rdata = {30'h0000_0000, cfg_dn.distance_mode,
                                  cfg_up.distance_mode};
                zone_pkg::OVR_UP_OFFSET:
                    next_rdata = {16'h0000, cfg_up.overrun};
                zone_pkg::OVR_DN_OFFSET:
                    next_rdata = {16'h0000, cfg_dn.overrun};
                zone_pkg::DEBOUNCE_OFFSET:
                    next_rdata = {24'h00_0000, debounce};
                zone_pkg::STATUS_OFFSET:
                    next_rdata = {26'h000_0000, busy_dn, busy_up,
                                  ROLLER_MOTOR_DN, ROLLER_MOTOR_UP,
                                  filt_r, filt_l};
                zone_pkg::CHATTER_L_OFFSET:
                    next_rdata = {16'h0000, chatter_l};
                zone_pkg::CHATTER_R_OFFSET:
                    next_rdata = {16'h0000, chatter_r};
                default:
                    next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            RDATA             <= 32'h0000_0000;
            ROLLER_MOTOR_UP   <= 1'b0;
            ROLLER_MOTOR_DN   <= 1'b0;
            SENSOR_L_FILTERED <= 1'b0;
            SENSOR_R_FILTERED <= 1'b0;
        end else begin
            RDATA             <= next_rdata;
            ROLLER_MOTOR_UP   <= ARRIVING_UP || busy_up;
            ROLLER_MOTOR_DN   <= ARRIVING_DN || busy_dn;
            SENSOR_L_FILTERED <= filt_l;
            SENSOR_R_FILTERED <= filt_r;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_overrun_runs;
        @(posedge REF_CLK) disable iff (!RST_B)
        start_up && (cfg_up.overrun != 16'h0000) |=>
            busy_up ##1 ROLLER_MOTOR_UP;
    endproperty
    a_overrun_runs: assert property (p_overrun_runs)
        else $error("Upstream overrun did not keep the motor on");

    property p_time_limit;
        @(posedge REF_CLK) disable iff (!RST_B)
        !cfg_up.distance_mode |->
            cfg_up.overrun <= zone_pkg::OVERRUN_TIME_MAX;
    endproperty
    a_time_limit: assert property (p_time_limit)
        else $error("Time overrun above limit");

    property p_zone_independent;
        @(posedge REF_CLK) disable iff (!RST_B)
        WSTRB && (ADDR == zone_pkg::OVR_UP_OFFSET) |=>
            $stable(cfg_dn.overrun);
    endproperty
    a_zone_independent: assert property (p_zone_independent)
        else $error("Upstream write changed downstream overrun");

    property p_distance_value;
        @(posedge REF_CLK) disable iff (!RST_B)
        WSTRB && (ADDR == zone_pkg::OVR_DN_OFFSET) &&
            cfg_dn.distance_mode |=>
            cfg_dn.overrun == $past(WDATA[15:0]);
    endproperty
    a_distance_value: assert property (p_distance_value)
        else $error("Distance overrun not stored whole");

    property p_hold_stable;
        @(posedge REF_CLK) disable iff (!RST_B)
        hold_l |=> $stable(filt_l);
    endproperty
    a_hold_stable: assert property (p_hold_stable)
        else $error("Left filter changed during hold");

    property p_lead_edge;
        @(posedge REF_CLK) disable iff (!RST_B)
        !hold_r && sync_b[1] && !filt_r |=> filt_r ##1 SENSOR_R_FILTERED;
    endproperty
    a_lead_edge: assert property (p_lead_edge)
        else $error("Blocking edge delayed");

    property p_trail_edge;
        @(posedge REF_CLK) disable iff (!RST_B)
        !hold_l && !sync_b[0] && filt_l && (debounce != 8'h00) |=>
            !filt_l && hold_l;
    endproperty
    a_trail_edge: assert property (p_trail_edge)
        else $error("Clearing edge delayed or not held");

    property p_chatter_count;
        @(posedge REF_CLK) disable iff (!RST_B)
        hold_l && $changed(sync_b[0]) |=>
            chatter_l == $past(chatter_l) + 16'h0001;
    endproperty
    a_chatter_count: assert property (p_chatter_count)
        else $error("Ignored change not counted");

    property p_debounce_limit;
        @(posedge REF_CLK) disable iff (!RST_B)
        debounce <= zone_pkg::DEBOUNCE_MAX;
    endproperty
    a_debounce_limit: assert property (p_debounce_limit)
        else $error("Debounce above limit");

    property p_tick_spacing;
        @(posedge REF_CLK) disable iff (!RST_B)
        tick |=> !tick && (tick_cnt == 32'h0000_0000);
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("Timebase tick malformed");

endmodule

// *** verification/zone_partner.sv ***
// Photo-sensor and travel-encoder model for the zone block
`timescale 1ns/1ns
module zone_partner (
    input  wire logic clk,
    output logic      sensor_l,
    output logic      sensor_r,
    output logic      travel_up,
    output logic      travel_dn
);
    initial begin
        sensor_l = 1'b0;
        sensor_r = 1'b0;
        travel_up = 1'b0;
        travel_dn = 1'b0;
    end

    // Gap sets how fast a sensor flickers: short gaps mimic chatter
    task automatic sense(input logic right, input logic level, input int gap);
        @(posedge clk);
        if (right) begin
            sensor_r <= level;
        end else begin
            sensor_l <= level;
        end
        repeat (gap) @(posedge clk);
    endtask

    // One pulse per mm; wide pulses so the synchroniser sees each edge
    task automatic pulses(input logic dn, input int n);
        repeat (n) begin
            @(posedge clk);
            if (dn) travel_dn <= 1'b1;
            else travel_up <= 1'b1;
            repeat (3) @(posedge clk);
            travel_dn <= 1'b0;
            travel_up <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
endmodule

// *** verification/zone_induct_debounce_tb.sv ***
// Self-checking bench for the zone overrun and debounce block
`timescale 1ns/1ns
module zone_induct_debounce_tb;
    logic        ref_clk;
    logic        rst_b;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wstrb;
    logic        rstrb;
    logic [31:0] rdata;
    logic        sensor_l;
    logic        sensor_r;
    logic        travel_up;
    logic        travel_dn;
    logic        arriving_up;
    logic        arriving_dn;
    logic        motor_up;
    logic        motor_dn;
    logic        filt_l;
    logic        filt_r;
    int          n_errors;
    int          num_checks;

    always #10 ref_clk = ~ref_clk;

    // Short tick keeps the run brief: one tick is 10 clocks
    zone_induct_debounce #(.TICK_CYCLES(10)) u_zone_induct_debounce (
        .REF_CLK(ref_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata),
        .WSTRB(wstrb), .RSTRB(rstrb), .RDATA(rdata),
        .SENSOR_L(sensor_l), .SENSOR_R(sensor_r),
        .TRAVEL_PULSE_UP(travel_up), .TRAVEL_PULSE_DN(travel_dn),
        .ARRIVING_UP(arriving_up), .ARRIVING_DN(arriving_dn),
        .ROLLER_MOTOR_UP(motor_up), .ROLLER_MOTOR_DN(motor_dn),
        .SENSOR_L_FILTERED(filt_l), .SENSOR_R_FILTERED(filt_r)
    );

    zone_partner u_zone_partner (
        .clk(ref_clk), .sensor_l(sensor_l), .sensor_r(sensor_r),
        .travel_up(travel_up), .travel_dn(travel_dn)
    );

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wstrb <= 1'b1;
        @(posedge ref_clk);
        wstrb <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rstrb <= 1'b1;
        @(posedge ref_clk);
        rstrb <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic end_of_test;
        $display("Checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Whole run is about 600 clocks; far beyond that means a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        rst_b = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wstrb = 1'b0;
        rstrb = 1'b0;
        arriving_up = 1'b0;
        arriving_dn = 1'b0;
        n_errors = 0;
        num_checks = 0;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(zone_pkg::CTRL_OFFSET, 32'h0);
        rd(zone_pkg::OVR_UP_OFFSET, 32'h0);
        rd(zone_pkg::OVR_DN_OFFSET, 32'h0);
        rd(zone_pkg::DEBOUNCE_OFFSET, 32'h0000000A);
        rd(zone_pkg::CHATTER_L_OFFSET, 32'h0);
        wr(zone_pkg::OVR_UP_OFFSET, 32'h0000FFFF);
        rd(zone_pkg::OVR_UP_OFFSET, 32'h00001964);
        wr(zone_pkg::CTRL_OFFSET, 32'h00000002);
        wr(zone_pkg::OVR_DN_OFFSET, 32'h0000FFFF);
        rd(zone_pkg::OVR_DN_OFFSET, 32'h0000FFFF);
        wr(zone_pkg::CTRL_OFFSET, 32'h00000001);
        rd(zone_pkg::CTRL_OFFSET, 32'h00000001);
        rd(zone_pkg::OVR_DN_OFFSET, 32'h00001964);
        wr(zone_pkg::CTRL_OFFSET, 32'h00000002);
        rd(zone_pkg::CTRL_OFFSET, 32'h00000002);
        wr(zone_pkg::DEBOUNCE_OFFSET, 32'h000000FF);
        rd(zone_pkg::DEBOUNCE_OFFSET, 32'h000000C8);
        wr(8'h20, 32'h00000005);
        rd(8'h20, 32'h0);
        wr(zone_pkg::OVR_UP_OFFSET, 32'h00000005);
        wr(zone_pkg::OVR_DN_OFFSET, 32'h00000007);
        rd(zone_pkg::OVR_UP_OFFSET, 32'h00000005);
        rd(zone_pkg::OVR_DN_OFFSET, 32'h00000007);
        wr(zone_pkg::DEBOUNCE_OFFSET, 32'h0000000A);
        $display("test registers done");
        u_zone_partner.sense(1'b0, 1'b1, 5);
        cyc(1);
        chk(32'(filt_l), 32'h1);
        for (int i = 0; i < 4; i++) begin
            u_zone_partner.sense(1'b0, i[0], 4);
        end
        cyc(1);
        chk(32'(filt_l), 32'h1);
        rd(zone_pkg::CHATTER_L_OFFSET, 32'h00000004);
        cyc(120);
        u_zone_partner.sense(1'b0, 1'b0, 5);
        cyc(1);
        chk(32'(filt_l), 32'h0);
        $display("test left debounce done");
        wr(zone_pkg::DEBOUNCE_OFFSET, 32'h00000002);
        u_zone_partner.sense(1'b1, 1'b1, 5);
        u_zone_partner.sense(1'b1, 1'b0, 4);
        cyc(1);
        chk(32'(filt_r), 32'h1);
        cyc(30);
        chk(32'(filt_r), 32'h0);
        rd(zone_pkg::CHATTER_R_OFFSET, 32'h00000001);
        $display("test shared debounce done");
        @(posedge ref_clk);
        arriving_up <= 1'b1;
        // Left hold from the clearing edge must run out first
        cyc(60);
        chk(32'(motor_up), 32'h1);
        u_zone_partner.sense(1'b0, 1'b1, 5);
        arriving_up <= 1'b0;
        cyc(20);
        chk(32'(motor_up), 32'h1);
        rd(zone_pkg::STATUS_OFFSET, 32'h00000015);
        cyc(40);
        chk(32'(motor_up), 32'h0);
        $display("test time overrun done");
        wr(zone_pkg::OVR_DN_OFFSET, 32'h00000004);
        @(posedge ref_clk);
        arriving_dn <= 1'b1;
        u_zone_partner.sense(1'b1, 1'b1, 5);
        arriving_dn <= 1'b0;
        cyc(150);
        chk(32'(motor_dn), 32'h1);
        u_zone_partner.pulses(1'b1, 3);
        cyc(5);
        chk(32'(motor_dn), 32'h1);
        u_zone_partner.pulses(1'b1, 1);
        cyc(8);
        chk(32'(motor_dn), 32'h0);
        $display("test distance overrun done");
        end_of_test();
    end
endmodule
